// file: hdl/asbt_pkg.sv
// constants and types for the async serial bit-timing block
package asbt_pkg;

    // ********************************************
    // field layout
    // ********************************************
    localparam int SEL_MSB = 3; // base clock select, bits 3..0
    localparam int SEL_LSB = 0;
    localparam int SEL_W = SEL_MSB - SEL_LSB + 1;
    localparam int DIV_W = 8;
    localparam int PRESC_W = 11;

    // ********************************************
    // limits and reset values
    // ********************************************
    localparam logic [DIV_W-1:0] DIV_MIN = 8'h08;
    localparam logic [DIV_W-1:0] DIV_MAX = 8'hff;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h08;
    localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'ha; // selections above clamp to 2^10

    // ********************************************
    // timing counts in base clocks
    // ********************************************
    localparam logic [DIV_W-1:0] RX_LATCH_MARGIN = 8'h02;
    localparam logic [1:0] TX_STOP_EXT = 2'h2;

    // transmit counter control states
    typedef enum logic [1:0] {TX_WAIT, TX_RUN, TX_STRETCH} asbt_tx_e;

endpackage : asbt_pkg

// file: hdl/asbt_baud_timing.sv
// bit-rate generator with separate transmit and receive timing counters
`timescale 1ns/10ps
module asbt_baud_timing (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // unit controls
    input wire logic unit_power_on,
    input wire logic transmit_enable,
    input wire logic receive_enable,
    input wire logic [asbt_pkg::SEL_W-1:0] base_clock_select,
    input wire logic [asbt_pkg::DIV_W-1:0] bit_rate_divisor,
    // transmitter side events
    input wire logic transmit_buffer_write,
    input wire logic tx_frame_end,
    input wire logic tx_next_pending,
    // receiver side events
    input wire logic rx_start_detect,
    input wire logic rx_frame_end,
    // timing outputs
    output logic base_tick,
    output logic tx_bit_tick,
    output logic rx_sample_tick,
    output logic [asbt_pkg::DIV_W-1:0] divisor_active
);
    import asbt_pkg::*;

    // ********************************************
    // state
    // ********************************************
    logic [PRESC_W-1:0] presc_ff, nxt_presc;
    logic base_tick_ff, nxt_base_tick;
    logic [DIV_W-1:0] divisor_ff, nxt_divisor;
    logic [SEL_W-1:0] sel_ff, nxt_sel;
    logic [DIV_W-1:0] tx_cnt_ff, nxt_tx_cnt;
    logic tx_phase_ff, nxt_tx_phase;
    asbt_tx_e tx_state_ff, nxt_tx_state;
    logic [1:0] stretch_ff, nxt_stretch;
    logic [DIV_W-1:0] rx_cnt_ff, nxt_rx_cnt;
    logic rx_phase_ff, nxt_rx_phase;
    logic rx_active_ff, nxt_rx_active;
    logic tx_bit_ff, nxt_tx_bit;
    logic rx_samp_ff, nxt_rx_samp;
    logic tx_on, rx_on, tx_half, rx_half;

    // prescaler tick: low sel bits of counter all ones
    function automatic logic presc_hit(input logic [PRESC_W-1:0] cnt, input logic [SEL_W-1:0] sel);
        logic [PRESC_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < PRESC_W - 1; i++)
        begin
            mask[i] = i < int'(sel);
        end
        return (cnt & mask) == mask;
    endfunction : presc_hit

    assign tx_on = unit_power_on & transmit_enable;
    assign rx_on = unit_power_on & receive_enable;
    assign tx_half = base_tick_ff && (tx_cnt_ff == divisor_ff - 8'h01);
    assign rx_half = base_tick_ff && rx_active_ff && (rx_cnt_ff == divisor_ff - 8'h01);

    // ********************************************
    // configuration and base clock
    // ********************************************
    always_comb
    begin
        nxt_divisor = divisor_ff;
        if (bit_rate_divisor >= DIV_MIN && bit_rate_divisor <= DIV_MAX)
        begin
            nxt_divisor = bit_rate_divisor;
        end
        nxt_sel = (base_clock_select > SEL_MAX) ? SEL_MAX : base_clock_select;
        nxt_presc = unit_power_on ? presc_ff + 11'h001 : 11'h000;
        nxt_base_tick = unit_power_on && presc_hit(presc_ff, sel_ff);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            divisor_ff <= DIV_RST;
            sel_ff <= SEL_RST;
            presc_ff <= '0;
            base_tick_ff <= 1'b0;
        end
        else
        begin
            divisor_ff <= nxt_divisor;
            sel_ff <= nxt_sel;
            presc_ff <= nxt_presc;
            base_tick_ff <= nxt_base_tick;
        end
    end

    // ********************************************
    // transmit counter
    // ********************************************
    always_comb
    begin
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_phase = tx_phase_ff;
        nxt_tx_state = tx_state_ff;
        nxt_stretch = stretch_ff;
        nxt_tx_bit = 1'b0;
        if (!tx_on)
        begin
            nxt_tx_cnt = '0;
            nxt_tx_phase = 1'b0;
            nxt_tx_state = TX_WAIT;
            nxt_stretch = '0;
        end
        else
        begin
            if (base_tick_ff)
            begin
                nxt_tx_cnt = tx_half ? 8'h00 : tx_cnt_ff + 8'h01;
                nxt_tx_phase = tx_half ? ~tx_phase_ff : tx_phase_ff;
                nxt_tx_bit = tx_half && tx_phase_ff;
            end
            unique case (tx_state_ff)
                TX_WAIT:
                begin
                    if (transmit_buffer_write)
                    begin
                        nxt_tx_cnt = '0;
                        nxt_tx_phase = 1'b0;
                        nxt_tx_bit = 1'b0;
                        nxt_tx_state = TX_RUN;
                    end
                end
                TX_RUN:
                begin
                    if (tx_frame_end && tx_next_pending)
                    begin
                        nxt_tx_cnt = '0;
                        nxt_tx_phase = 1'b0;
                        nxt_tx_bit = 1'b0;
                        nxt_stretch = '0;
                        nxt_tx_state = TX_STRETCH;
                    end
                    else if (tx_frame_end)
                    begin
                        nxt_tx_state = TX_WAIT; // keeps counting
                    end
                end
                TX_STRETCH:
                begin
                    // hold counter two base clocks, then restart cleared
                    nxt_tx_cnt = '0;
                    nxt_tx_phase = 1'b0;
                    nxt_tx_bit = 1'b0;
                    if (base_tick_ff)
                    begin
                        nxt_stretch = stretch_ff + 2'h1;
                        if (stretch_ff + 2'h1 == TX_STOP_EXT)
                        begin
                            nxt_tx_state = TX_RUN;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_cnt_ff <= '0;
            tx_phase_ff <= 1'b0;
            tx_state_ff <= TX_WAIT;
            stretch_ff <= '0;
            tx_bit_ff <= 1'b0;
        end
        else
        begin
            tx_cnt_ff <= nxt_tx_cnt;
            tx_phase_ff <= nxt_tx_phase;
            tx_state_ff <= nxt_tx_state;
            stretch_ff <= nxt_stretch;
            tx_bit_ff <= nxt_tx_bit;
        end
    end

    // ********************************************
    // receive counter
    // ********************************************
    always_comb
    begin
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_phase = rx_phase_ff;
        nxt_rx_active = rx_active_ff;
        nxt_rx_samp = 1'b0;
        if (!rx_on)
        begin
            nxt_rx_cnt = '0;
            nxt_rx_phase = 1'b0;
            nxt_rx_active = 1'b0;
        end
        else if (rx_start_detect)
        begin
            // filter delay already spent counts toward the first half bit
            nxt_rx_cnt = RX_LATCH_MARGIN;
            nxt_rx_phase = 1'b0;
            nxt_rx_active = 1'b1;
        end
        else if (rx_frame_end)
        begin
            nxt_rx_cnt = '0;
            nxt_rx_phase = 1'b0;
            nxt_rx_active = 1'b0;
        end
        else if (rx_active_ff && base_tick_ff)
        begin
            nxt_rx_cnt = rx_half ? 8'h00 : rx_cnt_ff + 8'h01;
            nxt_rx_phase = rx_half ? ~rx_phase_ff : rx_phase_ff;
            nxt_rx_samp = rx_half && !rx_phase_ff; // mid-bit latch
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_cnt_ff <= '0;
            rx_phase_ff <= 1'b0;
            rx_active_ff <= 1'b0;
            rx_samp_ff <= 1'b0;
        end
        else
        begin
            rx_cnt_ff <= nxt_rx_cnt;
            rx_phase_ff <= nxt_rx_phase;
            rx_active_ff <= nxt_rx_active;
            rx_samp_ff <= nxt_rx_samp;
        end
    end

    // outputs
    assign base_tick = base_tick_ff;
    assign tx_bit_tick = tx_bit_ff;
    assign rx_sample_tick = rx_samp_ff;
    assign divisor_active = divisor_ff;

    // ********************************************
    // assertions
    // ********************************************
    AST_DIV_RANGE: assert property (@(posedge clk) disable iff (rst)
        divisor_ff >= DIV_MIN)
        else $error("divisor below minimum");
    AST_DIV_REJECT: assert property (@(posedge clk) disable iff (rst)
        bit_rate_divisor < DIV_MIN |=> divisor_ff == $past(divisor_ff))
        else $error("illegal divisor accepted");
    AST_BASE_LOW: assert property (@(posedge clk) disable iff (rst)
        !unit_power_on [*2] |-> !base_tick_ff && !tx_bit_ff)
        else $error("base clock active while powered down");
    AST_TX_OFF: assert property (@(posedge clk) disable iff (rst)
        !tx_on |=> tx_cnt_ff == 8'h00 && tx_state_ff == TX_WAIT)
        else $error("tx counter not cleared when disabled");
    AST_TX_FIRST: assert property (@(posedge clk) disable iff (rst)
        tx_on && tx_state_ff == TX_WAIT && transmit_buffer_write |=> tx_cnt_ff == 8'h00 && tx_state_ff == TX_RUN)
        else $error("tx counter not cleared on first write");
    AST_TX_STRETCH: assert property (@(posedge clk) disable iff (rst)
        tx_state_ff == TX_RUN && tx_on && tx_frame_end && tx_next_pending |=> tx_cnt_ff == 8'h00 && tx_state_ff == TX_STRETCH)
        else $error("stop extension not entered");
    AST_TX_RESUME: assert property (@(posedge clk) disable iff (rst)
        tx_on && tx_state_ff == TX_STRETCH && base_tick_ff && stretch_ff == TX_STOP_EXT - 2'h1 |=> tx_cnt_ff == 8'h00 && tx_state_ff == TX_RUN)
        else $error("counter not restarted after stop extension");
    AST_RX_RESTART: assert property (@(posedge clk) disable iff (rst)
        rx_on && rx_start_detect |=> rx_active_ff && rx_cnt_ff == RX_LATCH_MARGIN && !rx_phase_ff)
        else $error("rx timing not restarted");
    AST_RX_OFF: assert property (@(posedge clk) disable iff (rst)
        !rx_on || (rx_frame_end && !rx_start_detect) |=> !rx_active_ff && rx_cnt_ff == 8'h00 && !rx_samp_ff)
        else $error("rx counter not halted");
    AST_HALF_PERIOD: assert property (@(posedge clk) disable iff (rst)
        tx_half && tx_on && tx_state_ff == TX_RUN && !tx_frame_end |=> tx_cnt_ff == 8'h00)
        else $error("half-bit boundary wrong");
    AST_SAMPLE_CAUSE: assert property (@(posedge clk) disable iff (rst)
        rx_samp_ff |-> $past(rx_half) && $past(rx_active_ff))
        else $error("sample without half-bit boundary");

    COV_TX_STRETCH: cover property (@(posedge clk) disable iff (rst) tx_state_ff == TX_STRETCH ##1 tx_state_ff == TX_RUN);
    COV_RX_SAMPLE: cover property (@(posedge clk) disable iff (rst) rx_samp_ff);
    COV_TX_BIT: cover property (@(posedge clk) disable iff (rst) tx_bit_ff);
    COV_RX_RESTART: cover property (@(posedge clk) disable iff (rst) rx_active_ff && rx_start_detect && rx_on);

endmodule : asbt_baud_timing

// file: verification/asbt_remote_tx.sv
// model of the remote transmitter: start and frame-end events
`timescale 1ns/10ps
module asbt_remote_tx (
    // clock
    input wire logic clk,
    // command from the bench
    input wire logic go,
    input wire logic [15:0] frame_len,
    // events toward the receiver
    output logic start_det,
    output logic frame_done
);
    int cnt = 0;
    // ************************
    // framing
    // ************************
    // a new start may cut a frame short; frame length stays in tolerance
    always @(negedge clk)
    begin
        start_det <= go;
        frame_done <= cnt == 1 && !go;
        cnt <= go ? int'(frame_len) : (cnt != 0 ? cnt - 1 : 0);
    end
endmodule : asbt_remote_tx

// file: verification/async_serial_baud_timing_test.sv
// self-checking testbench for the bit-rate timing block
`timescale 1ns/10ps
module async_serial_baud_timing_test;
    import asbt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwr = 1'b0, txe = 1'b0, rxe = 1'b0, pend = 1'b0;
    // one-cycle strobes: buffer write, frame end, remote start
    logic [2:0] pls = 3'b000;
    wire logic wr = pls[0];
    wire logic tfe = pls[1];
    wire logic go = pls[2];
    localparam int P_WR = 0;
    localparam int P_TFE = 1;
    localparam int P_GO = 2;
    logic [SEL_W-1:0] sel = 4'h0;
    logic [DIV_W-1:0] div = 8'h08;
    logic [DIV_W-1:0] act;
    logic [15:0] flen = 16'h0000;
    logic st, fe, bt, txt, rxt;
    logic [31:0] seed = 32'hbf40ae1b;
    int failures = 0, tests_run = 0, cyc = 0, t_ev = 0, t_tx = 0, t_rx = 0, n_b = 0, n_tx = 0, n_rx = 0;
    // ************************
    // clock, design and remote side
    // ************************
    always #20 clk = ~clk;
    asbt_baud_timing i_dut (.clk(clk), .rst(rst), .unit_power_on(pwr), .transmit_enable(txe),
        .receive_enable(rxe), .base_clock_select(sel), .bit_rate_divisor(div),
        .transmit_buffer_write(wr), .tx_frame_end(tfe), .tx_next_pending(pend),
        .rx_start_detect(st), .rx_frame_end(fe), .base_tick(bt), .tx_bit_tick(txt),
        .rx_sample_tick(rxt), .divisor_active(act));
    asbt_remote_tx i_remote (.clk(clk), .go(go), .frame_len(flen), .start_det(st), .frame_done(fe));
    // records the edge of each cause and each transmit or receive tick; base ticks are only counted
    always @(posedge clk)
    begin
        cyc++;
        if (wr === 1'b1 || tfe === 1'b1 || st === 1'b1) t_ev = cyc;
        if (bt === 1'b1) n_b++;
        if (txt === 1'b1) begin n_tx++; t_tx = cyc; end
        if (rxt === 1'b1) begin n_rx++; t_rx = cyc; end
    end
    // ************************
    // helpers
    // ************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // accepted divisor after offering v
    function automatic logic [DIV_W-1:0] acc(logic [DIV_W-1:0] prev, logic [DIV_W-1:0] v);
        return (v >= DIV_MIN) ? v : prev;
    endfunction : acc
    // edges from cause to n-th transmit tick
    function automatic int exp_tx(int k, int n, bit ext);
        return 2 * k * n + 1 + (ext ? int'(TX_STOP_EXT) : 0);
    endfunction : exp_tx
    // edges from start detection to n-th receive latch
    function automatic int exp_rx(int k, int n);
        return 2 * k * n - k - int'(RX_LATCH_MARGIN) + 1;
    endfunction : exp_rx
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input int b);
        @(negedge clk);
        pls[b] <= 1'b1;
        @(negedge clk);
        pls[b] <= 1'b0;
    endtask : pulse
    // bounded wait for the next tick; returns edges since the cause
    task automatic wait_tick(input bit rx, input int lim, output int at);
        int n0;
        n0 = rx ? n_rx : n_tx;
        at = -1;
        for (int i = 0; i < lim && at < 0; i++)
        begin
            @(negedge clk);
            if ((rx ? n_rx : n_tx) != n0) at = (rx ? t_rx : t_tx) - t_ev;
        end
        if (at < 0)
        begin
            failures++;
            conclude();
        end
    endtask : wait_tick
    // ************************
    // main sequence
    // ************************
    initial
    begin
        int k, at, n0;
        logic [DIV_W-1:0] v, e;
        repeat (4) @(negedge clk);
        chk(act, DIV_RST);
        rst <= 1'b0;
        pwr <= 1'b1;
        txe <= 1'b1;
        rxe <= 1'b1;
        e = DIV_RST;
        for (int i = 0; i < 24; i++)
        begin
            v = i == 0 ? 8'h07 : i == 1 ? 8'hff : i == 2 ? 8'h00 : i == 3 ? 8'h08 : 8'(rnd());
            div <= v;
            @(negedge clk);
            e = acc(e, v);
            chk(act, e);
        end
        for (int s = 0; s < 6; s++)
        begin
            sel <= 4'(s < 5 ? s : 11);
            repeat (1100) @(negedge clk);
            n0 = n_b;
            repeat (2048) @(negedge clk);
            chk(n_b - n0, 2048 >> (s < 5 ? s : 10));
        end
        pwr <= 1'b0;
        repeat (2) @(negedge clk);
        n0 = n_b + n_tx + n_rx;
        repeat (60) @(negedge clk);
        chk(n_b + n_tx + n_rx - n0, 0);
        pwr <= 1'b1;
        sel <= 4'h0;
        for (int i = 0; i < 6; i++)
        begin
            k = i == 0 ? 8 : i == 1 ? 255 : 8 + int'(rnd() % 33);
            div <= 8'(k);
            txe <= 1'b0;
            @(negedge clk);
            txe <= 1'b1;
            pend <= i[0];
            pulse(P_WR);
            wait_tick(1'b0, 600, at);
            chk(at, exp_tx(k, 1, 1'b0));
            wait_tick(1'b0, 600, at);
            chk(at, exp_tx(k, 2, 1'b0));
            pulse(P_TFE);
            wait_tick(1'b0, 600, at);
            if (i[0]) chk(at, exp_tx(k, 1, 1'b1));
            else chk(at, 2 * k - 2);
        end
        txe <= 1'b0;
        repeat (2) @(negedge clk);
        n0 = n_tx;
        repeat (600) @(negedge clk);
        chk(n_tx - n0, 0);
        for (int i = 0; i < 5; i++)
        begin
            k = i == 0 ? 8 : 8 + int'(rnd() % 33);
            div <= 8'(k);
            flen <= 16'(22 * k);
            pulse(P_GO);
            wait_tick(1'b1, 600, at);
            chk(at, exp_rx(k, 1));
            wait_tick(1'b1, 600, at);
            chk(at, exp_rx(k, 2));
            pulse(P_GO);
            wait_tick(1'b1, 600, at);
            chk(at, exp_rx(k, 1));
            repeat (22 * k + 4) @(negedge clk);
            n0 = n_rx;
            repeat (3 * k) @(negedge clk);
            chk(n_rx - n0, 0);
        end
        rxe <= 1'b0;
        pulse(P_GO);
        n0 = n_rx;
        repeat (200) @(negedge clk);
        chk(n_rx - n0, 0);
        conclude();
    end
endmodule : async_serial_baud_timing_test
